// File: rtl/fimon_top.sv
// Purpose: Fault input monitoring and core rail supervision with reactions
// Assumes: Pins and comparator outputs are asynchronous, classic Wishbone
// Notes: OTP bits arrive as static ports from the fuse block
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`include "fimon_defs.svh"

// Notes on behaviour
// - Fault inputs ignored unless OTP enable set
// - Evaluation starts after init phase closes
// - Two-bit mode field, pair default
// - Pair polarity selects faulty level pair
// - Pair fault: failsafe, plus reset if bit
// - Independent mode: separate inputs, own settings
// - Input a polarity selects faulty level
// - Input b polarity selects faulty level
// - Input a fault: failsafe, reset if bit
// - Input b fault: failsafe, reset if bit
// - Settings writable only during init phase
// - Overvoltage switches converter off while present
// - Supervision runs while failsafe active
// - Core monitor covers converter one, multiphase two
// - Overvoltage reaction field: none, fs, both
// - Undervoltage reaction field: none, fs, both
// - Overvoltage filter 25 or 45 us
// - Undervoltage filter 5/15/25/40 us
// - Recovery: failsafe and open recovery window
module fimon_top #(
   parameter int FLT_CYC = `FIMON_FLT_CYC,
   parameter int OV_SHORT_CYC = `FIMON_OV_SHORT_CYC,
   parameter int OV_LONG_CYC = `FIMON_OV_LONG_CYC,
   parameter int UV_0_CYC = `FIMON_UV_0_CYC,
   parameter int UV_1_CYC = `FIMON_UV_1_CYC,
   parameter int UV_2_CYC = `FIMON_UV_2_CYC,
   parameter int UV_3_CYC = `FIMON_UV_3_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Fault pins and comparators
   input wire logic fault_input_a,
   input wire logic fault_input_b,
   input wire logic core_ov_detect,
   input wire logic core_uv_detect,
   // Safety state from the watchdog logic
   input wire logic safety_init_phase,
   input wire logic failsafe_active,
   input wire logic good_refresh,
   input wire logic multiphase_mode,
   // OTP bits
   input wire logic fault_input_monitor_enable,
   input wire logic recovery_strategy_enable,
   input wire logic core_overvoltage_filter_select,
   input wire logic [1:0] core_undervoltage_filter_select,
   // Reactions
   output logic failsafe_output_n,
   output logic reset_output_n,
   output logic first_core_converter_off,
   output logic second_core_converter_off,
   output logic recovery_active,
   output logic [3:0] recovery_window_length
);

   // =====================================
   // Parameter checks
   if (FLT_CYC < 1 || FLT_CYC > 8191 || OV_SHORT_CYC < 1 || OV_SHORT_CYC > 8191 ||
       OV_LONG_CYC < 1 || OV_LONG_CYC > 8191 || UV_0_CYC < 1 || UV_1_CYC < 1 ||
       UV_2_CYC < 1 || UV_3_CYC < 1 || UV_3_CYC > 8191 || UV_2_CYC > 8191 ||
       UV_1_CYC > 8191 || UV_0_CYC > 8191) begin : g_bad_param
      $error("fimon_top: filter count out of range 1..8191");
   end

   fimon_pkg::fimon_state_s s;
   fimon_pkg::fimon_state_s next_s;

   // Deglitch step: output follows input after limit stable cycles
   function automatic logic [13:0] filt_step(input logic x, input logic o,
                                             input fimon_pkg::fimon_cnt_t c,
                                             input fimon_pkg::fimon_cnt_t lim);
      logic [13:0] r;
      r = {o, 13'h0000};
      if (x != o) begin
         if (c + 13'h0001 >= lim) begin
            r = {x, 13'h0000};
         end else begin
            r = {o, c + 13'h0001};
         end
      end
      return r;
   endfunction

   // =====================================
   // Combinational next state
   always_comb begin
      logic [13:0] fa;
      logic [13:0] fb;
      logic [13:0] fov;
      logic [13:0] fuv;
      fimon_pkg::fimon_cnt_t ov_lim;
      fimon_pkg::fimon_cnt_t uv_lim;
      fimon_pkg::fimon_mode_e mode;
      logic run;
      logic sup;
      logic fault_a;
      logic fault_b;
      logic rst_a;
      logic rst_b;
      logic ov_now;
      logic uv_now;
      logic fs_req;
      logic rst_req;
      logic in_fault;
      logic wr;
      logic [31:0] rd;
      next_s = s;
      fault_a = 1'b0;
      fault_b = 1'b0;
      rst_a = 1'b0;
      rst_b = 1'b0;
      rd = 32'h0000_0000;
      mode = fimon_pkg::fimon_mode_e'(s.config_q[`FIMON_CFG_MODE]);

      // Two-stage synchronisers for pins and comparators
      next_s.sync1 = {core_uv_detect, core_ov_detect, fault_input_b, fault_input_a};
      next_s.sync2 = s.sync1;

      // Filter lengths from OTP selects
      ov_lim = core_overvoltage_filter_select ? 13'(OV_LONG_CYC) : 13'(OV_SHORT_CYC);
      unique case (core_undervoltage_filter_select)
         2'b00: uv_lim = 13'(UV_0_CYC);
         2'b01: uv_lim = 13'(UV_1_CYC);
         2'b10: uv_lim = 13'(UV_2_CYC);
         2'b11: uv_lim = 13'(UV_3_CYC);
      endcase

      // Deglitch filters
      fa = filt_step(s.sync2[0], s.filt[0], s.cnt_a, 13'(FLT_CYC));
      fb = filt_step(s.sync2[1], s.filt[1], s.cnt_b, 13'(FLT_CYC));
      fov = filt_step(s.sync2[2], s.filt[2], s.cnt_ov, ov_lim);
      fuv = filt_step(s.sync2[3], s.filt[3], s.cnt_uv, uv_lim);
      next_s.filt = {fuv[13], fov[13], fb[13], fa[13]};
      next_s.cnt_a = fa[12:0];
      next_s.cnt_b = fb[12:0];
      next_s.cnt_ov = fov[12:0];
      next_s.cnt_uv = fuv[12:0];

      // Fault input evaluation
      run = fault_input_monitor_enable && !safety_init_phase;
      if (run) begin
         unique case (mode)
            fimon_pkg::fimon_off: begin
               fault_a = 1'b0;
            end
            fimon_pkg::fimon_pair: begin
               // Complementary pair from the MCU
               fault_a = s.config_q[`FIMON_CFG_PAIR_POL] ?
                         (s.filt[0] || !s.filt[1]) : (!s.filt[0] || s.filt[1]);
               rst_a = s.config_q[`FIMON_CFG_PAIR_REACT];
            end
            fimon_pkg::fimon_either: begin
               fault_a = s.filt[0] == s.config_q[`FIMON_CFG_A_POL];
               fault_b = s.filt[1] == s.config_q[`FIMON_CFG_B_POL];
               rst_a = s.config_q[`FIMON_CFG_A_REACT];
               rst_b = s.config_q[`FIMON_CFG_B_REACT];
            end
            fimon_pkg::fimon_a_only: begin
               fault_a = s.filt[0] == s.config_q[`FIMON_CFG_A_POL];
               rst_a = s.config_q[`FIMON_CFG_A_REACT];
            end
         endcase
      end
      in_fault = fault_a || fault_b;

      // Recovery window request replaces the reset reaction
      if (recovery_strategy_enable && in_fault &&
          s.config_q[`FIMON_CFG_RECOV] != 4'h0) begin
         next_s.recov = 1'b1;
      end else if (s.recov && good_refresh && !in_fault) begin
         next_s.recov = 1'b0;
      end
      if (recovery_strategy_enable && s.config_q[`FIMON_CFG_RECOV] != 4'h0) begin
         rst_a = 1'b0;
         rst_b = 1'b0;
      end

      // Core rail supervision
      sup = failsafe_active;
      ov_now = sup && s.filt[2];
      uv_now = sup && s.filt[3];
      next_s.conv1_off = ov_now;
      next_s.conv2_off = ov_now && multiphase_mode;

      // Combined reactions
      fs_req = in_fault || (ov_now && s.config_q[`FIMON_CFG_OV_REACT] != 2'b00) ||
               (uv_now && s.config_q[`FIMON_CFG_UV_REACT] != 2'b00);
      rst_req = (fault_a && rst_a) || (fault_b && rst_b) ||
                (ov_now && s.config_q[9]) ||
                (uv_now && s.config_q[11]);
      next_s.rst = rst_req;

      // Register read mux
      unique case (wb_adr_i)
         `FIMON_CONFIG_OFS: rd = {16'h0000, s.config_q};
         `FIMON_STATUS_OFS: rd = {24'h00_0000, run, s.recov, s.rst, s.fs,
                                  s.uv_flag, s.ov_flag, fault_b, fault_a};
         `FIMON_OTP_OFS: rd = {27'h000_0000, core_undervoltage_filter_select,
                               core_overvoltage_filter_select,
                               recovery_strategy_enable, fault_input_monitor_enable};
         default: rd = 32'h0000_0000;
      endcase

      // Wishbone handshake, one wait state
      wr = wb_cyc_i && wb_stb_i && !s.ack && wb_we_i;
      next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
      next_s.rdata = (wb_cyc_i && wb_stb_i && !s.ack) ? rd : s.rdata;

      // Settings only accepted during the init phase
      if (wr && wb_adr_i == `FIMON_CONFIG_OFS && safety_init_phase) begin
         if (wb_sel_i[0]) begin
            next_s.config_q[7:0] = wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            next_s.config_q[15:8] = wb_dat_i[15:8];
         end
      end

      // Sticky flags, write one to clear, set wins
      if (wr && wb_adr_i == `FIMON_STATUS_OFS && wb_sel_i[0]) begin
         if (wb_dat_i[`FIMON_ST_OV]) begin
            next_s.ov_flag = 1'b0;
         end
         if (wb_dat_i[`FIMON_ST_UV]) begin
            next_s.uv_flag = 1'b0;
         end
         if (wb_dat_i[`FIMON_ST_FS]) begin
            next_s.fs = 1'b0;
         end
      end
      if (ov_now) begin
         next_s.ov_flag = 1'b1;
      end
      if (uv_now) begin
         next_s.uv_flag = 1'b1;
      end
      if (fs_req) begin
         next_s.fs = 1'b1;
      end
   end

   // =====================================
   // State register
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s <= '0;
         s.config_q <= `FIMON_CFG_RESET;
      end else begin
         s <= next_s;
      end
   end

   // =====================================
   // Outputs straight from state
   assign wb_dat_o = s.rdata;
   assign wb_ack_o = s.ack;
   assign failsafe_output_n = !s.fs;
   assign reset_output_n = !s.rst;
   assign first_core_converter_off = s.conv1_off;
   assign second_core_converter_off = s.conv2_off;
   assign recovery_active = s.recov;
   assign recovery_window_length = s.config_q[`FIMON_CFG_RECOV];

endmodule

// File: rtl/fimon_defs.svh
// Purpose: Constants of the fault input and core rail monitor
// Assumes: 100 MHz clock
// Notes: Times in ns, cycle counts derived from them
`ifndef FIMON_DEFS_SVH
`define FIMON_DEFS_SVH

// =====================================
// Timing
`define FIMON_CLK_NS 10
`define FIMON_FLT_NS 4000
`define FIMON_OV_SHORT_NS 25000
`define FIMON_OV_LONG_NS 45000
`define FIMON_UV_0_NS 5000
`define FIMON_UV_1_NS 15000
`define FIMON_UV_2_NS 25000
`define FIMON_UV_3_NS 40000
`define FIMON_FLT_CYC (`FIMON_FLT_NS / `FIMON_CLK_NS)
`define FIMON_OV_SHORT_CYC (`FIMON_OV_SHORT_NS / `FIMON_CLK_NS)
`define FIMON_OV_LONG_CYC (`FIMON_OV_LONG_NS / `FIMON_CLK_NS)
`define FIMON_UV_0_CYC (`FIMON_UV_0_NS / `FIMON_CLK_NS)
`define FIMON_UV_1_CYC (`FIMON_UV_1_NS / `FIMON_CLK_NS)
`define FIMON_UV_2_CYC (`FIMON_UV_2_NS / `FIMON_CLK_NS)
`define FIMON_UV_3_CYC (`FIMON_UV_3_NS / `FIMON_CLK_NS)

// =====================================
// Register offsets (byte addresses)
`define FIMON_CONFIG_OFS 4'h0
`define FIMON_STATUS_OFS 4'h4
`define FIMON_OTP_OFS 4'h8

// =====================================
// Config fields
`define FIMON_CFG_MODE 1:0
`define FIMON_CFG_PAIR_POL 2
`define FIMON_CFG_PAIR_REACT 3
`define FIMON_CFG_A_POL 4
`define FIMON_CFG_B_POL 5
`define FIMON_CFG_A_REACT 6
`define FIMON_CFG_B_REACT 7
`define FIMON_CFG_OV_REACT 9:8
`define FIMON_CFG_UV_REACT 11:10
`define FIMON_CFG_RECOV 15:12
`define FIMON_CFG_RESET 16'hb6c9

// =====================================
// Status fields
`define FIMON_ST_A_FAULT 0
`define FIMON_ST_B_FAULT 1
`define FIMON_ST_OV 2
`define FIMON_ST_UV 3
`define FIMON_ST_FS 4
`define FIMON_ST_RST 5
`define FIMON_ST_RECOV 6
`define FIMON_ST_RUN 7

`endif

// File: rtl/fimon_pkg.sv
// Purpose: Types of the fault input and core rail monitor
// Assumes: Counters up to 13 bits
// Notes: Whole module state is one packed struct
package fimon_pkg;

   // =====================================
   // Input configuration
   typedef enum logic [1:0] {
      fimon_off,
      fimon_pair,
      fimon_either,
      fimon_a_only
   } fimon_mode_e;

   typedef logic [12:0] fimon_cnt_t;

   // =====================================
   // Complete state
   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      logic [3:0] filt;
      fimon_cnt_t cnt_a;
      fimon_cnt_t cnt_b;
      fimon_cnt_t cnt_ov;
      fimon_cnt_t cnt_uv;
      logic [15:0] config_q;
      logic ov_flag;
      logic uv_flag;
      logic fs;
      logic rst;
      logic recov;
      logic conv1_off;
      logic conv2_off;
      logic ack;
      logic [31:0] rdata;
   } fimon_state_s;

endpackage

// File: verification/fimon_chk.sv
// Purpose: Port-level properties of the fault input monitor
// Assumes: Synchronous active-low reset, classic Wishbone
// Notes: Bound into the top module after the checker
module fimon_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Safety state
   input wire logic safety_init_phase,
   input wire logic failsafe_active,
   input wire logic fault_input_monitor_enable,
   input wire logic multiphase_mode,
   // Reactions
   input wire logic failsafe_output_n,
   input wire logic reset_output_n,
   input wire logic first_core_converter_off,
   input wire logic second_core_converter_off
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // ==========
   // Bus handshake
   a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_data_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o)
      else $error("read data moved");
   // ==========
   // Reactions
   a_fs_latched: assert property (!failsafe_output_n && !(wb_cyc_i && wb_we_i)
      |=> !failsafe_output_n)
      else $error("failsafe released");
   a_rst_with_fs: assert property (!reset_output_n |-> !failsafe_output_n)
      else $error("reset without failsafe");
   a_fs_cause: assert property ($fell(failsafe_output_n) |-> $past(failsafe_active)
      || $past(fault_input_monitor_enable && !safety_init_phase))
      else $error("failsafe without cause");
   a_conv_gated: assert property (first_core_converter_off |-> $past(failsafe_active))
      else $error("converter off while idle");
   a_conv_pair: assert property (second_core_converter_off
      |-> first_core_converter_off && $past(multiphase_mode))
      else $error("second converter off");
   // Main scenarios
   c_ack: cover property (wb_ack_o);
   c_fs: cover property ($fell(failsafe_output_n));
   c_conv: cover property ($rose(second_core_converter_off));
endmodule

bind fimon_top fimon_chk chk (.*);

// File: verification/fimon_mcu.sv
// Purpose: Fault collection side model driving the two fault pins
// Assumes: Levels change just after a clock edge
// Notes: Pair mode keeps the pins complementary
module fimon_mcu (
   // Clock
   input wire logic clk,
   // Commands
   input wire logic pair,
   input wire logic pol,
   input wire logic flt,
   input wire logic [1:0] lv,
   // Fault pins
   output logic a = 1'h0,
   output logic b = 1'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   // Pair gives the faulty or healthy complement, else free levels
   always @(posedge clk) begin
      a <= pair ? (flt ? pol : ~pol) : lv[0];
      b <= pair ? (flt ? ~pol : pol) : lv[1];
   end
endmodule

// File: verification/tb_top.sv
// Purpose: Randomised self-checking bench of the fault input monitor
// Assumes: Short filter counts, recovery strategy enable random per round
// Notes: Each round resets, configures, closes init, compares
`include "fimon_defs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========
   // Design signals
   logic clk = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [3:0] wb_adr_i = 0, wb_sel_i = 4'h3, recovery_window_length;
   logic [31:0] wb_dat_i = 0, wb_dat_o, rd, r, q;
   logic wb_ack_o, fault_input_a, fault_input_b, core_ov_detect = 0, core_uv_detect = 0;
   logic safety_init_phase = 1, failsafe_active = 0, good_refresh = 0, multiphase_mode = 0;
   logic fault_input_monitor_enable = 0, recovery_strategy_enable = 0;
   logic core_overvoltage_filter_select = 0, failsafe_output_n, reset_output_n;
   logic first_core_converter_off, second_core_converter_off, recovery_active;
   logic [1:0] core_undervoltage_filter_select = 0, lv = 0;
   logic [2:0] e;
   logic pair = 0, pol = 0, flt = 0;
   logic [15:0] cfg;
   int num_errors = 0, cmp_count = 0;
   // Design with short filters, fault collection model on its pins
   fimon_top #(.FLT_CYC(4), .OV_SHORT_CYC(20), .OV_LONG_CYC(30), .UV_0_CYC(5),
      .UV_1_CYC(10), .UV_2_CYC(15), .UV_3_CYC(20)) uut (.*);
   fimon_mcu mcu (.clk(clk), .pair(pair), .pol(pol), .flt(flt), .lv(lv),
      .a(fault_input_a), .b(fault_input_b));
   // Clock
   always #5 clk = ~clk;
   // ==========
   // Verdict and comparison
   task automatic stop_test();
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
      cmp_count++;
      if (s !== x) begin
         num_errors++;
         $display("unexpected %s exp %h got %h", n, x, s);
      end
   endtask
   // Classic Wishbone cycle, bounded wait for ack seen between edges
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         num_errors++;
         stop_test();
      end
      // Ack stands until the next rising edge, which ends the request
      rd = wb_dat_o;
      @(posedge clk);
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
   endtask
   // Reference reaction {recovery, failsafe, reset}
   function automatic logic [2:0] model(input logic [15:0] c, input logic a, input logic b,
      input logic ov, input logic uv);
      int m, fs, rs, fi;
      m = fault_input_monitor_enable ? c[1:0] : 0;
      fs = 0;
      rs = 0;
      if (m == 1 && (c[2] ? (a || !b) : (!a || b))) begin
         fs = 1;
         rs = c[3];
      end
      if (m >= 2 && a == c[4]) begin
         fs = 1;
         rs |= c[6];
      end
      if (m == 2 && b == c[5]) begin
         fs = 1;
         rs |= c[7];
      end
      fi = fs;
      // Recovery keeps fault inputs off the reset output
      if (recovery_strategy_enable && c[15:12] != 0) begin
         rs = 0;
      end
      if (failsafe_active && ov && c[9:8] != 0) begin
         fs = 1;
         rs |= c[9];
      end
      if (failsafe_active && uv && c[11:10] != 0) begin
         fs = 1;
         rs |= c[11];
      end
      return {fi[0] & recovery_strategy_enable & (c[15:12] != 0), fs[0], rs[0]};
   endfunction
   // ==========
   // Random rounds
   initial begin
      int i;
      void'($urandom(32'h5687288f));
      for (i = 0; i < 50; i++) begin
         reset_n <= 0;
         safety_init_phase <= 1;
         core_ov_detect <= 0;
         core_uv_detect <= 0;
         r = $urandom;
         q = $urandom;
         cfg = r[15:0];
         fault_input_monitor_enable <= r[16] | r[17];
         recovery_strategy_enable <= r[28];
         wb_sel_i <= {r[27:26], 2'b11};
         failsafe_active <= r[18];
         multiphase_mode <= r[19];
         core_overvoltage_filter_select <= r[20];
         core_undervoltage_filter_select <= r[22:21];
         pair <= r[1:0] == 2'h1;
         pol <= r[2];
         flt <= r[23];
         lv <= r[25:24];
         repeat (i == 0 ? 5 : 2) @(posedge clk);
         reset_n <= 1;
         wb(0, `FIMON_CONFIG_OFS, 0);
         chk("config", 32'hb6c9, rd);
         chk("window", 4'hb, recovery_window_length);
         wb(0, 4'hc, 0);
         chk("unmapped", 0, rd);
         wb(1, `FIMON_CONFIG_OFS, {16'h0, cfg});
         wb(0, `FIMON_CONFIG_OFS, 0);
         chk("config", cfg, rd);
         repeat (12) @(posedge clk);
         chk("safety_init_phase", 1, failsafe_output_n);
         safety_init_phase <= 0;
         good_refresh <= 1;
         @(posedge clk);
         good_refresh <= 0;
         wb(1, `FIMON_CONFIG_OFS, {16'h0, ~cfg});
         wb(0, `FIMON_CONFIG_OFS, 0);
         chk("locked", cfg, rd);
         chk("window", cfg[15:12], recovery_window_length);
         core_ov_detect <= q[0];
         core_uv_detect <= q[1];
         repeat (60) @(posedge clk);
         e = model(cfg, fault_input_a, fault_input_b, q[0], q[1]);
         chk("failsafe", !e[1], failsafe_output_n);
         chk("reset", !e[0], reset_output_n);
         chk("recovery", e[2], recovery_active);
         chk("conv1", q[0] & failsafe_active, first_core_converter_off);
         chk("conv2", q[0] & failsafe_active & multiphase_mode, second_core_converter_off);
         core_ov_detect <= 0;
         core_uv_detect <= 0;
         repeat (40) @(posedge clk);
         e = model(cfg, fault_input_a, fault_input_b, 0, 0);
         chk("conv1 clear", 0, first_core_converter_off);
         chk("reset clear", !e[0], reset_output_n);
      end
      stop_test();
   end
endmodule
